/* File: rtl/status_pkg.sv */
// package: shared constants and carrier types for the status report groups
package status_pkg;
    localparam int REG_W = 15;
    localparam logic [14:0] REG_MAX = 15'h7FFF;
    localparam logic [14:0] ENABLE_RESET = 15'h0000;
    localparam logic [14:0] EVENT_RESET = 15'h0000;
    localparam int NUM_GROUPS = 3;
    localparam int GRP_ALARM = 0;
    localparam int GRP_OPER = 1;
    localparam int GRP_QUES = 2;
    localparam int QUEUE_DEPTH = 20;
    localparam int QPTR_W = 5;
    localparam logic [4:0] QUEUE_LAST = 5'h13;
    localparam logic [1:0] CROSS_NONE = 2'h0;
    localparam logic [1:0] CROSS_LOW = 2'h1;
    localparam logic [1:0] CROSS_HIGH = 2'h2;
    localparam logic [2:0] ALARM_NUM_MIN = 3'h1;
    localparam logic [2:0] ALARM_NUM_MAX = 3'h4;

    typedef enum logic [1:0] {
        SEL_ALARM,
        SEL_OPER,
        SEL_QUES,
        SEL_NONE
    } group_sel_type;

    typedef struct packed {
        logic [31:0] reading;
        logic [7:0] units;
        logic [31:0] date;
        logic [31:0] time_of_day;
        logic [15:0] channel;
        logic [1:0] crossed;
        logic [2:0] alarm_num;
    } alarm_rec_type;

    localparam int REC_W = $bits(alarm_rec_type);
endpackage

/* File: rtl/alarm_queue_mem.sv */
// alarm record storage with registered read data
`timescale 1ns/1ns
module alarm_queue_mem #(
    parameter int DEPTH = 20,
    parameter int AW = 5,
    parameter int W = 125
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem_ff [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    // read data are registered; the reader sees them one cycle after the address
    always_ff @(posedge clk) begin
        rd_data <= mem_ff[rd_addr];
    end
endmodule

/* File: rtl/status_report_groups.sv */
// status report groups: condition, event and enable registers plus the alarm queue
`timescale 1ns/1ns
module status_report_groups #(
    parameter int QUEUE_DEPTH = status_pkg::QUEUE_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [14:0] cond_alarm,
    input wire logic [14:0] cond_oper,
    input wire logic [14:0] cond_ques,
    input wire logic cond_read,
    input wire logic event_read,
    input wire logic enable_write,
    input wire logic enable_read,
    input wire status_pkg::group_sel_type group_sel,
    input wire logic [15:0] enable_wdata,
    input wire logic clear_status,
    input wire logic status_preset,
    input wire logic power_on_clear,
    input wire logic power_on_event,
    input wire logic alarm_push,
    input wire status_pkg::alarm_rec_type alarm_rec_in,
    input wire logic alarm_pop,
    input wire logic scan_start,
    output logic [15:0] read_data,
    output logic read_valid,
    output logic enable_range_err,
    output logic [2:0] summary,
    output status_pkg::alarm_rec_type alarm_rec_out,
    output logic alarm_valid,
    output logic alarm_empty,
    output logic queue_full,
    output logic [4:0] queue_count
);
    // ------------------------------------------------------------
    // condition inputs and group selection
    // ------------------------------------------------------------
    logic [14:0] cond_vec [3];
    logic [14:0] event_ff [3];
    logic [14:0] enable_ff [3];
    logic [14:0] cond_prev_ff [3];
    logic power_on_seen_ff;

    // condition bits are used as given; no storage on the way
    assign cond_vec[status_pkg::GRP_ALARM] = cond_alarm;
    assign cond_vec[status_pkg::GRP_OPER] = cond_oper;
    assign cond_vec[status_pkg::GRP_QUES] = cond_ques;

    // ------------------------------------------------------------
    // per-group event and enable registers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < status_pkg::NUM_GROUPS; g++) begin : grp
            logic sel_here;
            logic [14:0] rise;
            assign sel_here = (group_sel == status_pkg::group_sel_type'(g));
            // an occurrence is a rising condition bit
            assign rise = cond_vec[g] & ~cond_prev_ff[g];

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    cond_prev_ff[g] <= status_pkg::EVENT_RESET;
                end else begin
                    cond_prev_ff[g] <= cond_vec[g];
                end
            end

            // a new occurrence in the clearing cycle survives the clear
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    event_ff[g] <= status_pkg::EVENT_RESET;
                end else if (clear_status || (event_read && sel_here)) begin
                    event_ff[g] <= rise;
                end else begin
                    event_ff[g] <= event_ff[g] | rise;
                end
            end

            // enables are not reset by reset_n: they outlive a power cycle unless
            // power-on clear is on, which is applied at the first cycle after reset
            always_ff @(posedge clk) begin
                if (status_preset) begin
                    enable_ff[g] <= status_pkg::ENABLE_RESET;
                end else if (power_on_event && power_on_clear) begin
                    enable_ff[g] <= status_pkg::ENABLE_RESET;
                end else if (!power_on_seen_ff && power_on_clear) begin
                    enable_ff[g] <= status_pkg::ENABLE_RESET;
                end else if (enable_write && sel_here && !enable_wdata[15]) begin
                    enable_ff[g] <= enable_wdata[14:0];
                end
            end

            assign summary[g] = |(event_ff[g] & enable_ff[g]);
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            power_on_seen_ff <= 1'b0;
        end else begin
            power_on_seen_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // host read port
    // ------------------------------------------------------------
    logic [1:0] gi;
    assign gi = (group_sel == status_pkg::SEL_NONE) ? 2'h0 : 2'(group_sel);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            read_data <= 16'h0000;
            read_valid <= 1'b0;
            enable_range_err <= 1'b0;
        end else begin
            read_valid <= (cond_read || event_read || enable_read)
                && (group_sel != status_pkg::SEL_NONE);
            // out of range values are refused, stored value kept
            enable_range_err <= enable_write && enable_wdata[15];
            if (cond_read) begin
                read_data <= {1'b0, cond_vec[gi]};
            end else if (event_read) begin
                read_data <= {1'b0, event_ff[gi]};
            end else if (enable_read) begin
                read_data <= {1'b0, enable_ff[gi]};
            end
        end
    end

    // ------------------------------------------------------------
    // alarm queue
    // ------------------------------------------------------------
    logic [4:0] wr_ptr_ff;
    logic [4:0] rd_ptr_ff;
    logic [4:0] count_ff;
    logic do_push;
    logic do_pop;
    logic [status_pkg::REC_W-1:0] rd_word;

    assign queue_full = (count_ff == 5'(QUEUE_DEPTH));
    assign alarm_empty = (count_ff == 5'h00);
    assign queue_count = count_ff;
    // full queue keeps old records and drops the newcomer
    assign do_push = alarm_push && !queue_full && !scan_start;
    assign do_pop = alarm_pop && !alarm_empty && !scan_start;

    function automatic logic [4:0] ptr_inc(input logic [4:0] p);
        ptr_inc = (p == 5'(QUEUE_DEPTH - 1)) ? 5'h00 : p + 5'h01;
    endfunction

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_ff <= 5'h00;
            rd_ptr_ff <= 5'h00;
            count_ff <= 5'h00;
        end else if (scan_start) begin
            // a new scan throws away the previous scan's alarms
            wr_ptr_ff <= 5'h00;
            rd_ptr_ff <= 5'h00;
            count_ff <= 5'h00;
        end else begin
            if (do_push) begin
                wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            end
            if (do_pop) begin
                rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            end
            if (do_push && !do_pop) begin
                count_ff <= count_ff + 5'h01;
            end else if (do_pop && !do_push) begin
                count_ff <= count_ff - 5'h01;
            end
        end
    end

    alarm_queue_mem #(
        .DEPTH(QUEUE_DEPTH),
        .AW(status_pkg::QPTR_W),
        .W(status_pkg::REC_W)
    ) u_mem (
        .clk(clk),
        .wr_en(do_push),
        .wr_addr(wr_ptr_ff),
        .wr_data(alarm_rec_in),
        .rd_addr(rd_ptr_ff),
        .rd_data(rd_word)
    );

    // memory data arrive one cycle after the pop; alarm_rec_out and alarm_valid follow one cycle later
    logic pop_d_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pop_d_ff <= 1'b0;
            alarm_valid <= 1'b0;
        end else begin
            pop_d_ff <= do_pop;
            alarm_valid <= pop_d_ff;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_rec_out <= '0;
        end else if (pop_d_ff) begin
            alarm_rec_out <= status_pkg::alarm_rec_type'(rd_word);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_summary_alarm: assert property (@(posedge clk) disable iff (!reset_n)
        summary[0] == |(event_ff[0] & enable_ff[0]))
        else $error("alarm summary mismatch");
    chk_event_sticky: assert property (@(posedge clk) disable iff (!reset_n)
        (event_ff[1][0] && !clear_status && !(event_read && group_sel == status_pkg::SEL_OPER))
        |=> event_ff[1][0])
        else $error("event bit dropped without clear");
    chk_event_capture: assert property (@(posedge clk) disable iff (!reset_n)
        (cond_oper[0] && !cond_prev_ff[1][0]) |=> event_ff[1][0])
        else $error("rising condition not latched");
    chk_clear_status: assert property (@(posedge clk) disable iff (!reset_n)
        (clear_status && cond_ques == cond_prev_ff[2]) |=> event_ff[2] == 15'h0000)
        else $error("clear status did not clear");
    chk_preset_enables: assert property (@(posedge clk) disable iff (!reset_n)
        status_preset |=> (enable_ff[0] == 15'h0000 && enable_ff[1] == 15'h0000
            && enable_ff[2] == 15'h0000))
        else $error("preset left enable set");
    chk_enable_store: assert property (@(posedge clk) disable iff (!reset_n)
        (enable_write && group_sel == status_pkg::SEL_QUES && !enable_wdata[15]
            && !status_preset && !power_on_event && power_on_seen_ff)
        |=> enable_ff[2] == $past(enable_wdata[14:0]))
        else $error("enable write not stored");
    chk_cond_read: assert property (@(posedge clk) disable iff (!reset_n)
        (cond_read && group_sel == status_pkg::SEL_ALARM) |=> read_data == {1'b0, $past(cond_alarm)})
        else $error("condition read wrong");
    chk_queue_bound: assert property (@(posedge clk) disable iff (!reset_n)
        (queue_full && alarm_push && !alarm_pop && !scan_start) |=> queue_full)
        else $error("full queue changed on push");
    chk_pop_valid: assert property (@(posedge clk) disable iff (!reset_n)
        do_pop |-> ##2 alarm_valid)
        else $error("pop gave no record");
    chk_scan_clear: assert property (@(posedge clk) disable iff (!reset_n)
        scan_start |=> alarm_empty)
        else $error("scan start kept alarms");

    cov_queue_full: cover property (@(posedge clk) disable iff (!reset_n) queue_full);
    cov_pop: cover property (@(posedge clk) disable iff (!reset_n) alarm_valid);
    cov_summary: cover property (@(posedge clk) disable iff (!reset_n) summary[2]);
    cov_evt_read: cover property (@(posedge clk) disable iff (!reset_n)
        event_read && event_ff[0] != 15'h0000);
endmodule

/* File: tb/host_model.sv */
// host software model issuing status queries and settings
`timescale 1ns/1ns
module host_model (
    input wire logic clk,
    input wire logic [15:0] read_data,
    input wire logic read_valid,
    output status_pkg::group_sel_type group_sel,
    output logic cond_read,
    output logic event_read,
    output logic enable_read,
    output logic enable_write,
    output logic [15:0] enable_wdata,
    output logic clear_status,
    output logic status_preset
);
    initial begin
        group_sel = status_pkg::SEL_NONE;
        {cond_read, event_read, enable_read, enable_write} = 4'h0;
        {clear_status, status_preset} = 2'h0;
        enable_wdata = 16'h0000;
    end
    // kind 0 condition, 1 event, 2 enable; read_valid stands one cycle only
    task automatic query(input status_pkg::group_sel_type sel, input int kind,
                         output logic [15:0] data, output logic valid);
        @(negedge clk);
        group_sel = sel;
        cond_read = (kind == 0);
        event_read = (kind == 1);
        enable_read = (kind == 2);
        @(negedge clk);
        {cond_read, event_read, enable_read} = 3'h0;
        group_sel = status_pkg::SEL_NONE;
        valid = read_valid;
        data = read_data;
    endtask
    // values above the range are sent only where a refusal is expected
    task automatic write(input status_pkg::group_sel_type sel, input logic [15:0] val);
        @(negedge clk);
        group_sel = sel;
        enable_wdata = val;
        enable_write = 1'b1;
        @(negedge clk);
        enable_write = 1'b0;
        group_sel = status_pkg::SEL_NONE;
        enable_wdata = ~val;
    endtask
    // kind 0 clear status, 1 status preset
    task automatic pulse(input int kind);
        @(negedge clk);
        {status_preset, clear_status} = (kind == 0) ? 2'h1 : 2'h2;
        @(negedge clk);
        {status_preset, clear_status} = 2'h0;
    endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the status report groups
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [14:0] cond_alarm = 15'h0000, cond_oper = 15'h0000, cond_ques = 15'h0000;
    logic power_on_clear = 1'b1, power_on_event = 1'b0;
    logic alarm_push = 1'b0, alarm_pop = 1'b0, scan_start = 1'b0;
    status_pkg::alarm_rec_type alarm_rec_in = 125'h0, alarm_rec_out;
    status_pkg::group_sel_type group_sel;
    logic cond_read, event_read, enable_read, enable_write, clear_status, status_preset;
    logic [15:0] enable_wdata, read_data, d;
    logic read_valid, enable_range_err, alarm_valid, alarm_empty, queue_full, v;
    logic [2:0] summary;
    logic [4:0] queue_count;
    int n_mismatch = 0, comparisons = 0;
    always #50 clk = ~clk;
    status_report_groups i_dut (.clk(clk), .reset_n(reset_n), .cond_alarm(cond_alarm),
        .cond_oper(cond_oper), .cond_ques(cond_ques), .cond_read(cond_read),
        .event_read(event_read), .enable_write(enable_write), .enable_read(enable_read),
        .group_sel(group_sel), .enable_wdata(enable_wdata), .clear_status(clear_status),
        .status_preset(status_preset), .power_on_clear(power_on_clear),
        .power_on_event(power_on_event), .alarm_push(alarm_push), .alarm_rec_in(alarm_rec_in),
        .alarm_pop(alarm_pop), .scan_start(scan_start), .read_data(read_data),
        .read_valid(read_valid), .enable_range_err(enable_range_err), .summary(summary),
        .alarm_rec_out(alarm_rec_out), .alarm_valid(alarm_valid), .alarm_empty(alarm_empty),
        .queue_full(queue_full), .queue_count(queue_count));
    host_model i_host (.clk(clk), .read_data(read_data), .read_valid(read_valid),
        .group_sel(group_sel), .cond_read(cond_read), .event_read(event_read),
        .enable_read(enable_read), .enable_write(enable_write), .enable_wdata(enable_wdata),
        .clear_status(clear_status), .status_preset(status_preset));
    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [124:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic q(input int g, input int kind, input logic [15:0] exp);
        i_host.query(status_pkg::group_sel_type'(g), kind, d, v);
        check("read_valid", v, 1'b1);
        check("read_data", d, exp);
    endtask
    function automatic status_pkg::alarm_rec_type mk(input int i);
        mk = 125'h0;
        mk.reading = 32'h1000 + 32'(i);
        mk.date = 32'(i * 7);
        mk.channel = 16'(101 + i);
        mk.crossed = 2'(i % 3);
        mk.alarm_num = 3'(1 + i % 4);
    endfunction
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_cond();
        cond_alarm = 15'h7FFF;
        cond_oper = 15'h1234;
        cond_ques = 15'h0001;
        cyc(1);
        q(0, 0, 16'h7FFF);
        q(1, 0, 16'h1234);
        q(1, 0, 16'h1234);
        cond_oper = 15'h0000;
        cyc(1);
        q(1, 0, 16'h0000);
        q(2, 0, 16'h0001);
        i_host.query(status_pkg::SEL_NONE, 0, d, v);
        check("none_valid", v, 1'b0);
    endtask
    task automatic t_event();
        i_host.pulse(0);
        cond_alarm = 15'h0000;
        i_host.write(status_pkg::SEL_ALARM, 16'h0004);
        i_host.write(status_pkg::SEL_OPER, 16'h0001);
        cond_alarm = 15'h0005;
        cond_oper = 15'h0002;
        cyc(1);
        cond_alarm = 15'h0000;
        cyc(1);
        cond_alarm = 15'h0005;
        cyc(1);
        check("summary", summary, 3'h1);
        q(0, 1, 16'h0005);
        check("summary", summary, 3'h0);
        q(0, 1, 16'h0000);
        q(1, 1, 16'h0002);
        i_host.write(status_pkg::SEL_QUES, 16'h0008);
        cond_ques = 15'h0008;
        cyc(1);
        check("summary", summary, 3'h4);
        i_host.pulse(0);
        check("summary", summary, 3'h0);
        q(2, 1, 16'h0000);
    endtask
    task automatic t_enable();
        i_host.write(status_pkg::SEL_QUES, 16'h7FFF);
        check("range_err", enable_range_err, 1'b0);
        i_host.write(status_pkg::SEL_QUES, 16'h8000);
        check("range_err", enable_range_err, 1'b1);
        q(0, 2, 16'h0004);
        q(1, 2, 16'h0001);
        q(2, 2, 16'h7FFF);
        i_host.pulse(1);
        for (int g = 0; g < 3; g++) begin
            q(g, 2, 16'h0000);
        end
    endtask
    task automatic t_power();
        power_on_clear = 1'b0;
        i_host.write(status_pkg::SEL_OPER, 16'h0123);
        power_on_event = 1'b1;
        cyc(1);
        power_on_event = 1'b0;
        q(1, 2, 16'h0123);
        reset_n = 1'b0;
        cyc(1);
        reset_n = 1'b1;
        cyc(2);
        q(1, 2, 16'h0123);
        power_on_clear = 1'b1;
        power_on_event = 1'b1;
        cyc(1);
        power_on_event = 1'b0;
        q(1, 2, 16'h0000);
    endtask
    task automatic t_queue();
        for (int i = 0; i < 21; i++) begin
            alarm_rec_in = mk(i);
            alarm_push = 1'b1;
            cyc(1);
        end
        alarm_push = 1'b0;
        alarm_rec_in = ~mk(20);
        check("queue_count", queue_count, 5'h14);
        check("queue_full", queue_full, 1'b1);
        for (int i = 0; i < 20; i++) begin
            alarm_pop = 1'b1;
            cyc(1);
            alarm_pop = 1'b0;
            // alarm_valid stands only in the second cycle after the pop
            cyc(1);
            check("alarm_valid", alarm_valid, 1'b1);
            cyc(1);
            check("alarm_rec_out", alarm_rec_out, mk(i));
        end
        check("alarm_empty", alarm_empty, 1'b1);
        alarm_pop = 1'b1;
        cyc(1);
        alarm_pop = 1'b0;
        cyc(2);
        check("empty_pop_valid", alarm_valid, 1'b0);
        alarm_push = 1'b1;
        cyc(2);
        scan_start = 1'b1;
        cyc(1);
        {scan_start, alarm_push} = 2'h0;
        check("queue_count", queue_count, 5'h00);
    endtask
    initial begin
        cyc(3);
        reset_n = 1'b1;
        cyc(2);
        t_cond();
        t_event();
        t_enable();
        t_power();
        t_queue();
        end_sim();
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        #2000000;
        n_mismatch++;
        end_sim();
    end
endmodule
